// *** rtl/osd_pkg.sv ***
/*
 Package for the serial command decoder: command codes, field positions,
 reset values and link timing.
 Assumes a core clock of 250 MHz and a separate shift clock from the host.
*/
package osd_pkg;
	localparam int OSD_WORD_BITS = 8;
	localparam int OSD_ID_MSB = 7;
	localparam int OSD_ID_LSB = 4;
	localparam int OSD_FIRST_BIT = 7;
	localparam int OSD_ATTR_BIT = 7;
	localparam int OSD_FS_BIT = 6;
	localparam int OSD_VS2_BIT = 2;
	localparam int OSD_VS1_BIT = 0;
	localparam int OSD_ROW_W = 4;
	localparam int OSD_COL_W = 5;
	localparam int OSD_CODE_W = 6;
	localparam int OSD_VP_W = 6;
	localparam logic [4:0] OSD_COL_MAX = 5'h17;
	localparam logic [4:0] OSD_COL_RESET = 5'h00;
	localparam logic [3:0] OSD_ROW_RESET = 4'h0;
	localparam logic [5:0] OSD_VP_RESET = 6'h00;
	localparam real OSD_WORD_US = 4.2;
	localparam real OSD_WRITE_US = 1.0;
	localparam real OSD_CLK_MHZ = 250.0;
	localparam int OSD_WRITE_CYC = int'(OSD_WRITE_US * OSD_CLK_MHZ);

	typedef enum logic [3:0] {
		OSD_CMD_ADDR = 4'h8,
		OSD_CMD_CHAR = 4'h9,
		OSD_CMD_VERT = 4'hA,
		OSD_CMD_HORZ = 4'hB,
		OSD_CMD_DISP = 4'hC,
		OSD_CMD_SYNC = 4'hD
	} osd_cmd_e;

	typedef struct packed {
		logic attr;
		logic [5:0] code;
		logic [3:0] row;
		logic [4:0] col;
	} osd_char_s;

	typedef struct packed {
		logic line2_vertical_size;
		logic line1_vertical_size;
		logic crystal_rate_select;
		logic [5:0] vertical_start_position;
	} osd_vert_s;
endpackage

// *** rtl/osd_shift_rx.sv ***
/*
 Link-side shifter: gathers serial bits on the shift clock and hands each
 complete word to the core domain by a toggle.
 Assumes the shift clock only runs while select is low.
*/
`timescale 1ns/100ps
`default_nettype none
module osd_shift_rx
	import osd_pkg::*;
(
	input wire logic sclk, // Shift clock
	input wire logic serial_select_n, // Select, async
	input wire logic serial_data_in, // Serial data
	output logic [7:0] word, // Last full word
	output logic word_tgl // Toggles per word
);
	typedef struct packed {
		logic [6:0] sh;
		logic [2:0] cnt;
		logic [7:0] word;
		logic tgl;
	} osd_rx_s;
	osd_rx_s r, next_r;

	always_comb begin
		next_r = r;
		next_r.sh = {r.sh[5:0], serial_data_in};
		next_r.cnt = r.cnt + 3'd1;
		if (r.cnt == 3'd7) begin
			next_r.word = {r.sh, serial_data_in};
			next_r.tgl = ~r.tgl;
		end
	end

	// Select high clears the whole shifter, so a partial word is dropped
	// A toggle caused by this clear reaches the core after select high does
	always_ff @(posedge sclk or posedge serial_select_n) begin
		if (serial_select_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign word = r.word;
	assign word_tgl = r.tgl;
endmodule
`default_nettype wire

// *** rtl/osd_sync2.sv ***
/*
 Two-flop synchroniser for levels entering the core clock domain.
 Assumes the input is asynchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module osd_sync2
	import osd_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic clk, // Core clock
	input wire logic [W-1:0] d, // Async input
	output logic [W-1:0] q // Synchronised
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	initial begin
		if (W < 1) $error("W must be at least 1");
	end
	always_ff @(posedge clk) begin
		s1 <= d;
		s2 <= s1;
	end
	assign q = s2;
endmodule
`default_nettype wire

// *** rtl/osd_serial_command_decoder.sv ***
/*
 Serial command decoder: receives words over the select/shift clock/data
 link, decodes address, character and vertical setup commands.
 Assumes the reset pin is already synchronous to clk, and the host keeps
 its word and write spacing.
*/
`timescale 1ns/100ps
`default_nettype none
module osd_serial_command_decoder
	import osd_pkg::*;
(
	input wire logic clk, // Core clock 250 MHz
	input wire logic srst, // Reset pin, active high
	input wire logic sclk, // Link shift clock
	input wire logic serial_select_n, // Select, active low
	input wire logic serial_data_in, // Serial data
	output logic [3:0] cmd, // Current command code
	output logic char_lock, // Character write mode
	output logic [3:0] row_address, // Memory row
	output logic [4:0] column_address, // Memory column
	output logic char_we, // One-cycle write strobe
	output osd_char_s char_wr, // Write word with address
	output logic char_busy, // Memory write in progress
	output osd_vert_s vert_cfg // Vertical setup fields
);
	localparam logic [15:0] WRITE_CYC = 16'(OSD_WRITE_CYC);

	if (OSD_WRITE_CYC < 1 || OSD_WRITE_CYC > 65535) begin : g_cyc_check
		$error("write time does not fit the busy counter");
	end

	logic [7:0] rx_word;
	logic rx_tgl;
	logic [7:0] word_s;
	logic tgl_s;
	logic sel_s;

	osd_shift_rx u_rx (
		.sclk(sclk),
		.serial_select_n(serial_select_n),
		.serial_data_in(serial_data_in),
		.word(rx_word),
		.word_tgl(rx_tgl)
	);

	// Toggle takes one more stage in the core, so word_s has settled by then
	osd_sync2 #(.W(10)) u_sync (
		.clk(clk),
		.d({serial_select_n, rx_tgl, rx_word}),
		.q({sel_s, tgl_s, word_s})
	);

	typedef struct packed {
		logic tgl_q;
		logic tgl_d;
		logic [3:0] cmd;
		logic lock;
		logic [3:0] row;
		logic [4:0] col;
		logic we;
		osd_char_s wr;
		logic [15:0] busy;
		osd_vert_s vert;
	} osd_core_s;
	osd_core_s r, next_r;

	function automatic logic [4:0] col_step(input logic [4:0] c);
		col_step = (c >= OSD_COL_MAX) ? OSD_COL_RESET : c + 5'd1;
	endfunction

	logic word_new;
	assign word_new = r.tgl_q ^ r.tgl_d;

	always_comb begin
		next_r = r;
		next_r.tgl_q = tgl_s;
		next_r.tgl_d = r.tgl_q;
		next_r.we = 1'b0;
		if (r.busy != 16'h0000)
			next_r.busy = r.busy - 16'd1;
		if (sel_s) begin
			next_r.cmd = OSD_CMD_ADDR;
			next_r.lock = 1'b0;
		end else if (word_new) begin
			if (word_s[OSD_FIRST_BIT] && !r.lock) begin
				next_r.cmd = word_s[OSD_ID_MSB:OSD_ID_LSB];
				case (word_s[OSD_ID_MSB:OSD_ID_LSB])
					OSD_CMD_ADDR: next_r.row = word_s[OSD_ROW_W-1:0];
					OSD_CMD_CHAR: next_r.lock = 1'b1;
					OSD_CMD_VERT: begin
						next_r.vert.line2_vertical_size = word_s[OSD_VS2_BIT];
						next_r.vert.line1_vertical_size = word_s[OSD_VS1_BIT];
					end
					default: ;
				endcase
			end else begin
				case (r.cmd)
					OSD_CMD_ADDR: next_r.col = word_s[OSD_COL_W-1:0];
					OSD_CMD_CHAR: begin
						next_r.we = 1'b1;
						next_r.wr.attr = word_s[OSD_ATTR_BIT];
						next_r.wr.code = word_s[OSD_CODE_W-1:0];
						next_r.wr.row = r.row;
						next_r.wr.col = r.col;
						next_r.busy = WRITE_CYC;
						next_r.col = col_step(r.col);
					end
					OSD_CMD_VERT: begin
						next_r.vert.crystal_rate_select = word_s[OSD_FS_BIT];
						next_r.vert.vertical_start_position = word_s[OSD_VP_W-1:0];
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r <= '0;
			r.tgl_q <= tgl_s;
			r.tgl_d <= tgl_s;
		end else begin
			r <= next_r;
		end
	end

	assign cmd = r.cmd;
	assign char_lock = r.lock;
	assign row_address = r.row;
	assign column_address = r.col;
	assign char_we = r.we;
	assign char_wr = r.wr;
	assign char_busy = (r.busy != 16'h0000);
	assign vert_cfg = r.vert;

	a_select_cmd: assert property (@(posedge clk) disable iff (srst)
		!srst && sel_s |=> (r.cmd == OSD_CMD_ADDR) && !r.lock)
		else $error("select high did not restore address command");
	a_lock_hold: assert property (@(posedge clk) disable iff (srst)
		r.lock && !sel_s |=> r.lock && r.cmd == OSD_CMD_CHAR)
		else $error("character lock lost while select low");
	a_char_store: assert property (@(posedge clk) disable iff (srst)
		word_new && !sel_s && r.cmd == OSD_CMD_CHAR && (r.lock || !word_s[7])
		|=> char_we && char_wr.code == $past(word_s[5:0]) && char_wr.attr == $past(word_s[7]))
		else $error("character word not stored");
	a_col_adv: assert property (@(posedge clk) disable iff (srst)
		char_we |-> column_address == ((char_wr.col >= 5'h17) ? 5'h00 : char_wr.col + 5'd1))
		else $error("column did not advance");
	a_row_load: assert property (@(posedge clk) disable iff (srst)
		word_new && !sel_s && !r.lock && word_s[7:4] == 4'h8 |=> row_address == $past(word_s[3:0]))
		else $error("row not loaded");
	a_col_load: assert property (@(posedge clk) disable iff (srst)
		word_new && !sel_s && r.cmd == OSD_CMD_ADDR && !word_s[7] |=> column_address == $past(word_s[4:0]))
		else $error("column not loaded");
	a_vert_data: assert property (@(posedge clk) disable iff (srst)
		word_new && !sel_s && r.cmd == OSD_CMD_VERT && !word_s[7]
		|=> vert_cfg.vertical_start_position == $past(word_s[5:0])
		&& vert_cfg.crystal_rate_select == $past(word_s[6]))
		else $error("vertical data not loaded");
	a_vert_first: assert property (@(posedge clk) disable iff (srst)
		word_new && !sel_s && !r.lock && word_s[7:4] == 4'hA
		|=> vert_cfg.line2_vertical_size == $past(word_s[2]) && vert_cfg.line1_vertical_size == $past(word_s[0]))
		else $error("vertical size not loaded");
	a_reset_clear: assert property (@(posedge clk)
		srst |=> r.cmd == 4'h0 && !char_we && vert_cfg == '0 && row_address == 4'h0)
		else $error("reset did not clear registers");
	a_select_quiet: assert property (@(posedge clk) disable iff (srst)
		!srst && sel_s |=> !char_we)
		else $error("memory write while select high");
	a_cmd_held: assert property (@(posedge clk) disable iff (srst)
		!srst && word_new && !sel_s && !word_s[7] |=> cmd == $past(r.cmd))
		else $error("data word changed the command");
	a_busy_span: assert property (@(posedge clk) disable iff (srst)
		char_we |-> r.busy == WRITE_CYC)
		else $error("write busy span not started");
	a_we_pulse: assert property (@(posedge clk) disable iff (srst)
		char_we |=> !char_we)
		else $error("write strobe longer than one cycle");
endmodule
`default_nettype wire

// *** verif/osd_host_model.sv ***
/*
 Host model for the serial command link: drives select, shift clock and data.
 Assumes the testbench calls its tasks hierarchically, one at a time.
*/
`timescale 1ns/100ps
`default_nettype none
module osd_host_model (
	output logic sclk, // Shift clock, idles high
	output logic serial_select_n, // Select, active low
	output logic serial_data_in // Serial data, pulled up
);
	initial begin
		sclk = 1'b1;
		serial_select_n = 1'b0;
		serial_data_in = 1'b1;
		// Rising select after time zero clears the link shifter
		#10 serial_select_n = 1'b1;
	end
	// Select change, then 1 us settle
	task automatic sel(input logic v);
		serial_select_n = v;
		#1000;
	endtask
	// MSB first, n bits of one word
	task automatic send(input logic [7:0] w, input int n = 8);
		for (int i = 7; i > 7 - n; i--) begin
			serial_data_in = w[i];
			sclk = 1'b0;
			#40;
			sclk = 1'b1;
			#40;
		end
		#200;
		serial_data_in = 1'b1;
		#3600;
	endtask
endmodule
`default_nettype wire

// *** verif/tb_osd_serial_command_decoder.sv ***
/*
 Testbench for the serial command decoder: walks address, vertical,
 character and lock sequences through the host model.
 Assumes a 250 MHz core clock and an 80 ns shift clock.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module tb_osd_serial_command_decoder
	import osd_pkg::*;
;
	logic clk;
	logic srst;
	wire sclk;
	wire sel_n;
	wire sdi;
	logic [3:0] cmd;
	logic char_lock;
	logic [3:0] row_address;
	logic [4:0] column_address;
	logic char_we;
	osd_char_s char_wr;
	logic char_busy;
	osd_vert_s vert_cfg;
	osd_char_s last_char;
	int we_cnt = 0;
	int busy_cyc = 0;
	int error_cnt = 0;
	int num_checks = 0;

	osd_host_model host (.sclk(sclk), .serial_select_n(sel_n), .serial_data_in(sdi));
	osd_serial_command_decoder DUT (.clk(clk), .srst(srst), .sclk(sclk), .serial_select_n(sel_n),
		.serial_data_in(sdi), .cmd(cmd), .char_lock(char_lock), .row_address(row_address),
		.column_address(column_address), .char_we(char_we), .char_wr(char_wr),
		.char_busy(char_busy), .vert_cfg(vert_cfg));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Capture each memory write
	always @(posedge clk) begin
		if (char_we === 1'b1) begin
			last_char <= char_wr;
			we_cnt <= we_cnt + 1;
		end
		if (char_busy === 1'b1) begin
			busy_cyc <= busy_cyc + 1;
		end
	end

	task automatic finish_test();
		$display("Checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		#200000;
		error_cnt++;
		finish_test();
	end

	initial begin
		srst = 1'b1;
		repeat (7) @(posedge clk);
		#1;
		`CHK({cmd, char_lock, row_address, column_address}, 14'h0000)
		`CHK({char_we, char_busy}, 2'h0)
		`CHK(vert_cfg, 9'h000)
		@(posedge clk);
		srst <= 1'b0;
		repeat (10) @(posedge clk);
		#1.3;
		`CHK(cmd, 4'h8)
		host.sel(1'b0);
		host.send(8'h85);
		`CHK({cmd, row_address}, 8'h85)
		host.send(8'h03);
		`CHK(column_address, 5'h03)
		host.send(8'hA5);
		`CHK({cmd, vert_cfg}, {4'hA, 9'h180})
		host.send(8'h4A);
		`CHK(vert_cfg, 9'h1CA)
		host.send(8'h90);
		`CHK({cmd, char_lock}, 5'h13)
		host.send(8'h81);
		`CHK(last_char, 16'h82A3)
		`CHK(column_address, 5'h04)
		host.send(8'h3F);
		`CHK(last_char, 16'h7EA4)
		host.send(8'hA0);
		`CHK({cmd, char_lock, last_char}, 21'h13C0A5)
		host.sel(1'b1);
		`CHK({cmd, char_lock}, 5'h10)
		host.sel(1'b0);
		host.send(8'h80);
		host.send(8'h17);
		host.send(8'h90);
		host.send(8'h05);
		`CHK(last_char, 16'h0A17)
		`CHK(column_address, 5'h00)
		`CHK(we_cnt, 4)
		`CHK(busy_cyc, 4 * OSD_WRITE_CYC)
		host.sel(1'b1);
		host.sel(1'b0);
		for (int k = 0; k < 3; k++) begin
			host.send({4'hB + 4'(k), 4'h0});
			`CHK({cmd, vert_cfg}, {4'hB + 4'(k), 9'h1CA})
		end
		host.sel(1'b1);
		host.sel(1'b0);
		host.send(8'h8F, 4);
		host.sel(1'b1);
		host.sel(1'b0);
		host.send(8'h87);
		`CHK({cmd, row_address}, 8'h87)
		host.sel(1'b1);
		finish_test();
	end
endmodule
`default_nettype wire
